/* design/filt_pkg.sv */
package filt_pkg;
    localparam int DW = 24;
    localparam int AW = 16;
    localparam int MW = 12;
    localparam logic [3:0] REG_IN = 4'h0;
    localparam logic [3:0] REG_OUT = 4'h1;
    localparam logic [3:0] REG_CNT = 4'h3;
    localparam logic [3:0] REG_CSR = 4'h4;
    localparam logic [3:0] REG_ACR = 4'h5;
    localparam logic [3:0] REG_DBA = 4'h6;
    localparam logic [3:0] REG_CBA = 4'h7;
    localparam logic [3:0] REG_DCH = 4'h8;
    localparam int CSR_EN = 0;
    localparam int CSR_TYPE = 1;
    localparam int CSR_MLC = 6;
    localparam int CSR_PRC = 7;
    localparam int CSR_CONT = 13;
    localparam int CSR_IBE = 14;
    localparam int CSR_OBF = 15;
    localparam logic [23:0] CSR_WMASK = 24'h000dff;
    localparam logic [23:0] CNT_MASK = 24'h000fff;
    localparam logic [23:0] ACR_MASK = 24'h00007f;
    localparam logic [23:0] DCH_MASK = 24'h000f3f;
    localparam logic [23:0] CSR_FIR_RUN = 24'h000081;
    localparam logic [23:0] CSR_IIR_RUN = 24'h000003;
    localparam logic [23:0] ACR_SCALE8 = 24'h000001;
    localparam logic [AW-1:0] MEM_LIMIT = 16'h1000;
    localparam int FIFO_DEPTH = 4;
    localparam int BUF_DEPTH = 2;
    localparam logic [1:0] SCL_X8 = 2'h1;
    localparam logic [1:0] SCL_X16 = 2'h2;
endpackage : filt_pkg

/* design/filt_if.sv */
`timescale 1ns/10ps
interface filt_if;
    import filt_pkg::*;
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;
    logic rvalid;
    logic in_req;
    logic out_req;
    modport dev (input wr, rd, addr, wdata, output rdata, rvalid, in_req, out_req);
    modport host (output wr, rd, addr, wdata, input rdata, rvalid, in_req, out_req);
endinterface : filt_if

/* design/filt_host.sv */
`timescale 1ns/10ps
module filt_host
    import filt_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    filt_if.host bus,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [3:0] cmd_addr,
    input wire logic [DW-1:0] cmd_data,
    output logic cmd_ready,
    output logic [DW-1:0] rsp_data,
    output logic rsp_valid,
    output logic in_req_r,
    output logic out_req_r
);
    // ----------------------------------------
    // Single access per command
    // ----------------------------------------
    logic busy_r;
    assign cmd_ready = ~busy_r;
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            bus.wr <= 1'b0;
            bus.rd <= 1'b0;
            bus.addr <= 4'h0;
            bus.wdata <= '0;
            busy_r <= 1'b0;
        end else begin
            bus.wr <= 1'b0;
            bus.rd <= 1'b0;
            if (cmd_valid && !busy_r) begin
                // Sessions, tap counts, zeroed reserved bits, DMA sizes are software's choice
                bus.wr <= cmd_write;
                bus.rd <= ~cmd_write;
                bus.addr <= cmd_addr;
                bus.wdata <= cmd_data;
                busy_r <= ~cmd_write;
            end else if (bus.rvalid) begin
                busy_r <= 1'b0;
            end
        end
    end
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rsp_data <= '0;
            rsp_valid <= 1'b0;
            in_req_r <= 1'b0;
            out_req_r <= 1'b0;
        end else begin
            rsp_valid <= bus.rvalid;
            if (bus.rvalid) begin
                rsp_data <= bus.rdata;
            end
            in_req_r <= bus.in_req;
            out_req_r <= bus.out_req;
        end
    end
endmodule : filt_host

/* design/filt_dev.sv */
`timescale 1ns/10ps
module filt_dev
    import filt_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    filt_if.dev bus,
    output logic [AW-1:0] mem_addr_r,
    output logic [DW-1:0] mem_wdata_r,
    output logic mem_we_r,
    input wire logic mem_busy,
    output logic [AW-1:0] coef_addr_r,
    input wire logic [DW-1:0] res_data,
    input wire logic res_valid,
    output logic res_ready_r,
    output logic [3:0] dec_factor_r,
    output logic [5:0] chan_count_r,
    output logic [1:0] scale_shift_r,
    output logic enable_r
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [AW-1:0] kmask(input logic [MW-1:0] cnt);
        logic [AW-1:0] m;
        m = '0;
        for (int i = 0; i < MW; i++) begin
            if (cnt >> i != 0) m[i] = 1'b1;
        end
        return m;
    endfunction : kmask

    logic [DW-1:0] cnt_r, csr_r, acr_r, dch_r;
    logic [AW-1:0] dba_r, cba_r, cptr_r;
    logic [AW-1:0] dmask, dlow, dhigh, clow, chigh;
    logic wr_cnt, wr_csr, wr_acr, wr_dba, wr_cba, wr_dch, wr_in, rd_out;
    assign dmask = kmask(cnt_r[MW-1:0]);
    assign dlow = dba_r & ~dmask;
    assign dhigh = dlow + {4'h0, cnt_r[MW-1:0]};
    assign clow = cba_r & ~dmask;
    assign chigh = clow + {4'h0, cnt_r[MW-1:0]};
    assign wr_in = bus.wr && bus.addr == REG_IN;
    assign wr_cnt = bus.wr && bus.addr == REG_CNT;
    assign wr_csr = bus.wr && bus.addr == REG_CSR;
    assign wr_acr = bus.wr && bus.addr == REG_ACR;
    assign wr_dba = bus.wr && bus.addr == REG_DBA;
    assign wr_cba = bus.wr && bus.addr == REG_CBA;
    assign wr_dch = bus.wr && bus.addr == REG_DCH;
    assign rd_out = bus.rd && bus.addr == REG_OUT;

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cnt_r <= '0;
            acr_r <= '0;
            dch_r <= '0;
            cba_r <= '0;
        end else begin
            if (wr_cnt) cnt_r <= bus.wdata & CNT_MASK;
            if (wr_acr) acr_r <= bus.wdata & ACR_MASK;
            if (wr_dch) dch_r <= bus.wdata & DCH_MASK;
            if (wr_cba) cba_r <= bus.wdata[AW-1:0];
        end
    end
    logic cont_set;
    assign cont_set = mem_busy && (mem_we_r || csr_r[CSR_EN]);
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            csr_r <= '0;
        end else begin
            if (wr_csr) csr_r[12:0] <= bus.wdata[12:0] & CSR_WMASK[12:0];
            if (wr_csr && !bus.wdata[CSR_CONT]) csr_r[CSR_CONT] <= 1'b0;
            if (cont_set) csr_r[CSR_CONT] <= 1'b1;
        end
    end

    // ----------------------------------------
    // Input FIFO and data pointer
    // ----------------------------------------
    logic [DW-1:0] fifo_mem [FIFO_DEPTH];
    logic [1:0] f_wp, f_rp;
    logic [2:0] f_cnt;
    logic pop;
    assign pop = f_cnt != 0 && enable_r && !mem_busy;
    always_ff @(posedge clock) begin
        if (!rst_n || !csr_r[CSR_EN]) begin
            f_wp <= 2'h0;
            f_rp <= 2'h0;
            f_cnt <= 3'h0;
        end else begin
            if (wr_in && f_cnt != 3'(FIFO_DEPTH)) begin
                fifo_mem[f_wp] <= bus.wdata;
                f_wp <= f_wp + 2'h1;
            end
            if (pop) f_rp <= f_rp + 2'h1;
            f_cnt <= f_cnt + 3'(wr_in && f_cnt != 3'(FIFO_DEPTH)) - 3'(pop);
        end
    end
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            dba_r <= '0;
            mem_we_r <= 1'b0;
            mem_addr_r <= '0;
            mem_wdata_r <= '0;
        end else begin
            mem_we_r <= pop;
            // Store every popped sample, even when software loads the pointer
            if (pop) begin
                mem_addr_r <= dba_r & (MEM_LIMIT - 16'h1);
                mem_wdata_r <= fifo_mem[f_rp];
            end
            if (wr_dba) begin
                dba_r <= bus.wdata[AW-1:0];
            end else if (pop) begin
                dba_r <= (dba_r >= dhigh) ? dlow : dba_r + 16'h1;
            end
        end
    end

    // ----------------------------------------
    // Coefficient walk
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cptr_r <= '0;
            coef_addr_r <= '0;
        end else begin
            if (!enable_r || pop) cptr_r <= clow;
            else if (cptr_r != chigh) cptr_r <= cptr_r + 16'h1;
            coef_addr_r <= cptr_r & (MEM_LIMIT - 16'h1);
        end
    end

    // ----------------------------------------
    // Result buffer, two entries
    // ----------------------------------------
    logic [DW-1:0] ob_mem [BUF_DEPTH];
    logic ob_wp, ob_rp;
    logic [1:0] ob_cnt;
    logic ob_push, ob_pop;
    logic [DW-1:0] scaled;
    always_comb begin
        case (acr_r[1:0])
            SCL_X8: scaled = res_data <<< 3;
            SCL_X16: scaled = res_data <<< 4;
            default: scaled = res_data;
        endcase
    end
    assign ob_push = res_valid && res_ready_r;
    assign ob_pop = rd_out && ob_cnt != 0;
    always_ff @(posedge clock) begin
        if (!rst_n || !csr_r[CSR_EN]) begin
            ob_wp <= 1'b0;
            ob_rp <= 1'b0;
            ob_cnt <= 2'h0;
            res_ready_r <= 1'b0;
        end else begin
            if (ob_push) begin
                ob_mem[ob_wp] <= scaled;
                ob_wp <= ~ob_wp;
            end
            if (ob_pop) ob_rp <= ~ob_rp;
            ob_cnt <= ob_cnt + 2'(ob_push) - 2'(ob_pop);
            res_ready_r <= (ob_cnt + 2'(ob_push) - 2'(ob_pop)) < 2'(BUF_DEPTH);
        end
    end

    // ----------------------------------------
    // Read answers and outputs
    // ----------------------------------------
    logic [DW-1:0] status;
    always_comb begin
        status = csr_r;
        status[CSR_IBE] = f_cnt == 0;
        status[CSR_OBF] = ob_cnt != 0;
    end
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            bus.rdata <= '0;
            bus.rvalid <= 1'b0;
            bus.in_req <= 1'b0;
            bus.out_req <= 1'b0;
            dec_factor_r <= 4'h0;
            chan_count_r <= 6'h0;
            scale_shift_r <= 2'h0;
            enable_r <= 1'b0;
        end else begin
            bus.rvalid <= bus.rd;
            case (bus.addr)
                REG_OUT: bus.rdata <= ob_mem[ob_rp];
                REG_CNT: bus.rdata <= cnt_r;
                REG_CSR: bus.rdata <= status;
                REG_ACR: bus.rdata <= acr_r;
                REG_DBA: bus.rdata <= {8'h0, dba_r};
                REG_CBA: bus.rdata <= {8'h0, clow};
                REG_DCH: bus.rdata <= dch_r;
                default: bus.rdata <= '0;
            endcase
            bus.in_req <= csr_r[CSR_EN] && f_cnt == 0;
            bus.out_req <= csr_r[CSR_EN] && ob_cnt != 0 && !ob_pop;
            dec_factor_r <= dch_r[11:8];
            chan_count_r <= csr_r[CSR_MLC] ? dch_r[5:0] : 6'h0;
            scale_shift_r <= acr_r[1:0];
            enable_r <= csr_r[CSR_EN];
        end
    end
endmodule : filt_dev

/* sim/filt_properties.sv */
`timescale 1ns/10ps
module filt_properties
    import filt_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic wr,
    input wire logic rd,
    input wire logic [3:0] addr,
    input wire logic [DW-1:0] wdata,
    input wire logic [DW-1:0] rdata,
    input wire logic rvalid,
    input wire logic in_req,
    input wire logic out_req
);
    // ----------------------------------------
    // Shadow registers and assertions
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic [DW-1:0] cnt_r, cba_r, dch_r, csr_r;
    logic [AW-1:0] smear;
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cnt_r <= '0;
            cba_r <= '0;
            dch_r <= '0;
            csr_r <= '0;
        end else if (wr) begin
            if (addr == REG_CNT) cnt_r <= wdata & CNT_MASK;
            if (addr == REG_CBA) cba_r <= wdata;
            if (addr == REG_DCH) dch_r <= wdata & DCH_MASK;
            if (addr == REG_CSR) csr_r <= wdata & CSR_WMASK;
        end
    end
    always_comb begin
        smear = cnt_r[AW-1:0];
        smear = smear | (smear >> 1);
        smear = smear | (smear >> 2);
        smear = smear | (smear >> 4);
        smear = smear | (smear >> 8);
    end
    read_answer_a: assert property (rd |=> rvalid)
        else $error("read not answered next cycle");
    no_spurious_a: assert property (rvalid |-> $past(rd))
        else $error("answer without read");
    cba_lower_a: assert property (rd && addr == REG_CBA |=> rdata[AW-1:0] == (cba_r[AW-1:0] & ~smear))
        else $error("coefficient pointer read not lower boundary");
    cnt_read_a: assert property (rd && addr == REG_CNT |=> rdata == cnt_r)
        else $error("tap count readback wrong");
    dch_read_a: assert property (rd && addr == REG_DCH |=> rdata == dch_r)
        else $error("decimation register readback wrong");
    csr_read_a: assert property (rd && addr == REG_CSR |=> (rdata & CSR_WMASK) == csr_r)
        else $error("control readback wrong");
    reset_quiet_a: assert property (wr && addr == REG_CSR && !wdata[CSR_EN] |-> ##[1:3] (!in_req && !out_req))
        else $error("requests stay after individual reset");
    enable_req_a: assert property (wr && addr == REG_CSR && wdata[CSR_EN] && !csr_r[CSR_EN] |-> ##[1:4] in_req)
        else $error("no input request after enable");
endmodule : filt_properties

/* sim/filter_coprocessor_addr_config_test.sv */
`timescale 1ns/10ps
module filter_coprocessor_addr_config_test
    import filt_pkg::*;
;
    // ----------------------------------------
    // Bench
    // ----------------------------------------
    logic clock = 0, rst_n = 0, cmd_valid, cmd_write, mem_busy, res_valid;
    logic [3:0] cmd_addr;
    logic [DW-1:0] cmd_data, res_data, q, rsp_data, mem_wdata_r;
    logic cmd_ready, rsp_valid, in_req_r, out_req_r, mem_we_r, res_ready_r, enable_r;
    logic [AW-1:0] mem_addr_r, coef_addr_r, wq[$];
    logic [3:0] dec_factor_r;
    logic [5:0] chan_count_r;
    logic [1:0] scale_shift_r;
    int err_total = 0, check_count = 0;
    always #12.5 clock = ~clock;
    filt_if bus_i();
    filt_host filt_host_i(.clock(clock), .rst_n(rst_n), .bus(bus_i), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_ready(cmd_ready), .rsp_data(rsp_data),
        .rsp_valid(rsp_valid), .in_req_r(in_req_r), .out_req_r(out_req_r));
    filt_dev filt_dev_i(.clock(clock), .rst_n(rst_n), .bus(bus_i), .mem_addr_r(mem_addr_r),
        .mem_wdata_r(mem_wdata_r), .mem_we_r(mem_we_r), .mem_busy(mem_busy), .coef_addr_r(coef_addr_r),
        .res_data(res_data), .res_valid(res_valid), .res_ready_r(res_ready_r), .dec_factor_r(dec_factor_r),
        .chan_count_r(chan_count_r), .scale_shift_r(scale_shift_r), .enable_r(enable_r));
    filt_properties filt_properties_i(.clock(clock), .rst_n(rst_n), .wr(bus_i.wr), .rd(bus_i.rd),
        .addr(bus_i.addr), .wdata(bus_i.wdata), .rdata(bus_i.rdata), .rvalid(bus_i.rvalid),
        .in_req(bus_i.in_req), .out_req(bus_i.out_req));
    logic [DW-1:0] wdq[$];
    always @(posedge clock) begin
        if (mem_we_r === 1'b1) begin
            wq.push_back(mem_addr_r);
            wdq.push_back(mem_wdata_r);
        end
    end
    task end_of_test;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test
    task chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task limit(input int n);
        if (n >= 60) begin
            err_total++;
            $display("BAD %0t wait limit reached", $time);
            end_of_test;
        end
    endtask : limit
    task acc(input logic w, input logic [3:0] a, input logic [DW-1:0] d);
        int n;
        n = 0;
        @(negedge clock);
        cmd_valid = 1;
        cmd_write = w;
        cmd_addr = a;
        cmd_data = d;
        while (cmd_ready !== 1'b1 && n < 60) begin
            @(negedge clock);
            n++;
        end
        limit(n);
        @(negedge clock);
        cmd_valid = 0;
        n = 0;
        while (!w && rsp_valid !== 1'b1 && n < 60) begin
            @(negedge clock);
            n++;
        end
        limit(n);
        q = rsp_data;
        repeat (3) @(negedge clock);
    endtask : acc
    task rd_chk(input logic [3:0] a, input logic [DW-1:0] exp);
        acc(0, a, '0);
        chk(q, exp);
    endtask : rd_chk
    task push(input logic [DW-1:0] d);
        int n;
        n = 0;
        @(negedge clock);
        res_valid = 1;
        res_data = d;
        while (res_ready_r !== 1'b1 && n < 60) begin
            @(negedge clock);
            n++;
        end
        limit(n);
        @(negedge clock);
        res_valid = 0;
    endtask : push
    initial begin
        cmd_valid = 0; cmd_write = 0; cmd_addr = '0; cmd_data = '0; mem_busy = 0; res_valid = 0; res_data = '0;
        repeat (4) @(negedge clock);
        rst_n = 1;
        acc(1, REG_CNT, 24'h000005);
        rd_chk(REG_CNT, 24'h000005);
        acc(1, REG_DCH, 24'h000523);
        rd_chk(REG_DCH, 24'h000523);
        acc(1, REG_CBA, 24'h000010);
        rd_chk(REG_CBA, 24'h000010);
        acc(1, REG_DBA, 24'h000013);
        rd_chk(REG_DBA, 24'h000013);
        $display("test config done");
        acc(1, REG_CSR, CSR_FIR_RUN);
        chk(24'(enable_r), 24'h000001);
        chk(24'(dec_factor_r), 24'h000005);
        chk(24'(chan_count_r), 24'h000000);
        for (int i = 0; i < 4; i++) acc(1, REG_IN, 24'h0a0000 + 24'(i));
        for (int i = 0; i < 60 && wq.size() < 4; i++) @(negedge clock);
        if (wq.size() < 4) limit(60);
        for (int i = 0; i < 4; i++) chk(24'(wq[i]), 24'h000010 + 24'((i + 3) % 6));
        for (int i = 0; i < 4; i++) chk(wdq[i], 24'h0a0000 + 24'(i));
        rd_chk(REG_DBA, 24'h000011);
        chk(24'(coef_addr_r), 24'h000015);
        $display("test samples done");
        @(negedge clock) mem_busy = 1;
        @(negedge clock) mem_busy = 0;
        acc(0, REG_CSR, '0);
        chk(24'(q[CSR_CONT]), 24'h000001);
        acc(0, REG_CSR, '0);
        chk(24'(q[CSR_CONT]), 24'h000001);
        push(24'h111111);
        push(24'h222222);
        repeat (2) @(negedge clock);
        chk(24'(out_req_r), 24'h000001);
        rd_chk(REG_OUT, 24'h111111);
        rd_chk(REG_OUT, 24'h222222);
        chk(24'(out_req_r), 24'h000000);
        $display("test results done");
        acc(1, REG_CSR, 24'h000000);
        chk(24'(enable_r), 24'h000000);
        chk(24'(in_req_r), 24'h000000);
        rd_chk(REG_CNT, 24'h000005);
        rd_chk(REG_DCH, 24'h000523);
        acc(1, REG_DBA, 24'h00001d);
        acc(1, REG_CSR, 24'h000041);
        chk(24'(chan_count_r), 24'h000023);
        acc(1, REG_IN, 24'h0b0000);
        for (int i = 0; i < 60 && wq.size() < 5; i++) @(negedge clock);
        if (wq.size() < 5) limit(60);
        chk(24'(wq[4]), 24'h00001d);
        rd_chk(REG_DBA, 24'h000018);
        acc(1, REG_CSR, 24'h000000);
        acc(1, REG_CNT, 24'h000002);
        acc(1, REG_ACR, 24'h000002);
        chk(24'(scale_shift_r), 24'(SCL_X16));
        acc(1, REG_ACR, ACR_SCALE8);
        chk(24'(scale_shift_r), 24'(SCL_X8));
        acc(1, REG_CSR, CSR_IIR_RUN);
        acc(0, REG_CSR, '0);
        chk(q & CSR_WMASK, CSR_IIR_RUN);
        push(24'h000011);
        rd_chk(REG_OUT, 24'h000088);
        $display("test sessions done");
        end_of_test;
    end
endmodule : filter_coprocessor_addr_config_test
